// [shared/ctxq_pkg.sv]
// Contract
// - FIFO put index names the next buffer to fill; each add advances it.
// - Full flag is set when the put index catches up with the get index.
// - Adding n consecutive messages advances the put index cyclically by n.
// - Cancelling the get buffer moves get to next pending and recomputes free.
// - Cancelling any other buffer leaves get index and free level alone.
// - Free element address is start address plus put index times element size.
// - Queue mode select bit at 1 selects queue instead of FIFO operation.
// - In queue mode pending messages leave in ascending identifier order.
// - Equal identifiers leave lowest buffer number first.
// - In queue mode each add moves the put index cyclically to a free buffer.
// - Full queue is flagged, put index invalid; software adds nothing then.
// - Buffers split into dedicated count and FIFO size; size zero means dedicated only.
// - Dedicated buffers compete with the FIFO get buffer by lowest identifier.
// - Mixed queue mode splits dedicated and queue buffers; zero queue means dedicated only.
package ctxq_pkg;
   localparam int unsigned NBUF        = 32;
   // Register offsets
   localparam logic [7:0]  A_CFG       = 8'h00;
   localparam logic [7:0]  A_ELEM      = 8'h04;
   localparam logic [7:0]  A_STAT      = 8'h08;
   localparam logic [7:0]  A_ADD       = 8'h0C;
   localparam logic [7:0]  A_CANCEL    = 8'h10;
   localparam logic [7:0]  A_PEND      = 8'h14;
   localparam logic [7:0]  A_IRQ_ST    = 8'h18;
   localparam logic [7:0]  A_IRQ_MASK  = 8'h1C;
   localparam logic [7:0]  A_NEXT      = 8'h20;
   localparam logic [7:0]  A_ID_SEL    = 8'h24;
   localparam logic [7:0]  A_ID_DATA   = 8'h28;
   // Field positions
   localparam int unsigned CFG_DED_LSB = 16;
   localparam int unsigned CFG_SZ_LSB  = 24;
   localparam int unsigned CFG_QUEUE   = 31;
   localparam int unsigned ST_GET_LSB  = 8;
   localparam int unsigned ST_PUT_LSB  = 16;
   localparam int unsigned ST_FULL     = 24;
   localparam int unsigned IRQ_DONE    = 0;
   localparam int unsigned IRQ_CANCEL  = 1;
   localparam int unsigned IRQ_FULL    = 2;
   // Reset values
   localparam logic [4:0]  RST_ELEM    = 5'h04;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ctxq_bus_s;

   typedef struct packed {
      logic       done;
      logic [4:0] index;
   } ctxq_eng_in_s;

   typedef struct packed {
      logic        valid;
      logic [4:0]  index;
      logic [28:0] id;
      logic [15:0] addr;
   } ctxq_eng_out_s;

   typedef struct packed {
      logic [15:0]       start;
      logic [5:0]        ded;
      logic [5:0]        size;
      logic              queue;
      logic [4:0]        elem;
      logic [31:0]       pend;
      logic [31:0][28:0] ids;
      logic [4:0]        id_sel;
      logic [4:0]        get_off;
      logic [5:0]        fill;
      logic [4:0]        put_off;
      logic              full;
      logic [2:0]        irq_st;
      logic [2:0]        irq_mask;
      logic [31:0]       rdata;
      ctxq_eng_out_s     tx;
   } ctxq_state_s;
endpackage

// [core/ctxq_min.sv]
`timescale 1ns/1ns
module ctxq_min (
   // Clock for checks only
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Candidates
   input  wire logic [31:0]       mask,
   input  wire logic [31:0][28:0] ids,
   // Winner
   output logic                   found,
   output logic [4:0]             idx
);
   import ctxq_pkg::*;
   logic beaten;

   // Strict less-than keeps the lowest buffer number on equal identifiers
   // lowest id wins
   always_comb begin
      found = 1'b0;
      idx   = 5'h00;
      for (int i = 0; i < NBUF; i++) begin
         if (mask[i] && (!found || ids[i] < ids[idx])) begin
            found = 1'b1;
            idx   = 5'(i);
         end
      end
   end

   // Helper: does any candidate beat the chosen one
   always_comb begin
      beaten = 1'b0;
      for (int i = 0; i < NBUF; i++) begin
         if (mask[i] && (ids[i] < ids[idx] || (ids[i] == ids[idx] && 5'(i) < idx))) begin
            beaten = 1'b1;
         end
      end
   end

   property p_prio;
      @(posedge clk) disable iff (!rst_n) found |-> !beaten && mask[idx];
   endproperty
   a_prio: assert property (p_prio) else $error("winner is not lowest id");
   property p_none;
      @(posedge clk) disable iff (!rst_n) (mask == 32'h0) |-> !found;
   endproperty
   a_none: assert property (p_none) else $error("winner without candidate");
endmodule

// [core/ctxq_core.sv]
`timescale 1ns/1ns
module ctxq_core (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Register port
   input  wire ctxq_pkg::ctxq_bus_s bus,
   output logic [31:0]            rdata,
   // Protocol engine
   input  wire ctxq_pkg::ctxq_eng_in_s eng_i,
   output ctxq_pkg::ctxq_eng_out_s eng_o,
   // Interrupt
   output logic                   irq
);
   import ctxq_pkg::*;

   ctxq_state_s s_q;
   ctxq_state_s s_d;
   logic [5:0]  ded;
   logic [5:0]  sz;
   logic [63:0] qwide;
   logic [63:0] dwide;
   logic [31:0] qmask;
   logic [31:0] dmask;
   logic [4:0]  get_abs;
   logic [4:0]  put_off;
   logic [4:0]  put_abs;
   logic        full_now;
   logic [5:0]  free_lvl;
   logic [15:0] put_addr;
   logic [31:0] clr;
   logic [31:0] cancel_m;
   logic [31:0] addm;
   logic [31:0] pend_n;
   logic [5:0]  add_cnt;
   logic [5:0]  skip;
   logic [5:0]  step;
   logic [31:0] cand;
   logic        win_found;
   logic [4:0]  win_idx;
   logic [2:0]  ev;
   logic        wr_add;
   logic        wr_cancel;

   function automatic logic [4:0] wrap(input logic [5:0] a, input logic [5:0] s);
      wrap = (a >= s) ? 5'(a - s) : 5'(a);
   endfunction

   function automatic logic [5:0] popc(input logic [31:0] v);
      popc = 6'h00;
      for (int i = 0; i < NBUF; i++) begin
         popc = popc + {5'h00, v[i]};
      end
   endfunction

   // Buffer split, clamped so dedicated plus FIFO never passes 32
   // area split
   always_comb begin
      ded   = (s_q.ded > 6'd32) ? 6'd32 : s_q.ded;
      sz    = (7'(ded) + 7'(s_q.size) > 7'd32) ? 6'(6'd32 - ded) : s_q.size;
      qwide = ((64'h1 << sz) - 64'h1) << ded;
      dwide = (64'h1 << ded) - 64'h1;
      qmask = qwide[31:0];
      dmask = dwide[31:0];
   end

   // Indexes, full flag, free level and the free element address
   always_comb begin
      get_abs = 5'(ded + 6'(s_q.get_off));
      put_off = s_q.queue ? s_q.put_off : wrap(6'(s_q.get_off) + s_q.fill, sz);
      put_abs = 5'(ded + 6'(put_off));
      if (s_q.queue) begin
         full_now = (sz != 6'h00) && ((qmask & ~s_q.pend) == 32'h0);
         free_lvl = popc(qmask & ~s_q.pend);
      end else begin
         full_now = (sz != 6'h00) && (s_q.fill == sz);
         free_lvl = 6'(sz - s_q.fill);
      end
      put_addr = s_q.start + 16'(10'(put_abs) * 10'(s_q.elem));
   end

   // Candidates: dedicated buffers, plus the whole queue or only the oldest FIFO entry
   // candidate set
   always_comb begin
      if (s_q.queue) begin
         cand = s_q.pend & (dmask | qmask);
      end else if (s_q.fill != 6'h00) begin
         cand = s_q.pend & (dmask | (32'h1 << get_abs));
      end else begin
         cand = s_q.pend & dmask;
      end
   end

   ctxq_min u_min (
      .clk   (clk),
      .rst_n (rst_n),
      .mask  (cand),
      .ids   (s_q.ids),
      .found (win_found),
      .idx   (win_idx)
   );

   // Next state: removals first, then the get scan, then new requests
   always_comb begin
      s_d       = s_q;
      s_d.rdata = 32'h0;
      wr_add    = bus.wr && (bus.addr == A_ADD);
      wr_cancel = bus.wr && (bus.addr == A_CANCEL);
      cancel_m  = wr_cancel ? (bus.wdata & s_q.pend) : 32'h0;
      clr       = cancel_m | (eng_i.done ? (32'h1 << eng_i.index) : 32'h0);
      pend_n    = s_q.pend & ~clr;
      skip      = s_q.fill;
      step      = 6'h00;
      addm      = 32'h0;
      add_cnt   = 6'h00;

      // Register writes
      if (bus.wr) begin
         case (bus.addr)
            A_CFG: begin
               s_d.start = bus.wdata[15:0];
               s_d.ded   = bus.wdata[CFG_DED_LSB +: 6];
               s_d.size  = bus.wdata[CFG_SZ_LSB +: 6];
               s_d.queue = bus.wdata[CFG_QUEUE];
            end
            A_ELEM:     s_d.elem     = bus.wdata[4:0];
            A_IRQ_MASK: s_d.irq_mask = bus.wdata[2:0];
            A_ID_SEL:   s_d.id_sel   = bus.wdata[4:0];
            A_ID_DATA:  s_d.ids[s_q.id_sel] = bus.wdata[28:0];
            default: begin
            end
         endcase
      end

      // Get buffer gone: skip to the next still-pending FIFO entry
      // get advance
      if (!s_q.queue && s_q.fill != 6'h00 && !pend_n[get_abs]) begin
         for (int k = NBUF - 1; k >= 1; k--) begin
            if (6'(k) < s_q.fill && pend_n[5'(ded + 6'(wrap(6'(s_q.get_off) + 6'(k), sz)))]) begin
               skip = 6'(k);
            end
         end
         s_d.get_off = wrap(6'(s_q.get_off) + skip, sz);
         s_d.fill    = 6'(s_q.fill - skip);
      end

      // New requests only for idle buffers inside the configured area
      // batch add
      if (wr_add) begin
         addm    = bus.wdata & (dmask | qmask) & ~pend_n;
         add_cnt = popc(addm & qmask);
         if (!s_q.queue) begin
            s_d.fill = s_d.fill + add_cnt;
         end
      end
      pend_n   = pend_n | addm;
      s_d.pend = pend_n;

      // Queue put index hops to the next free buffer once its own is taken
      // queue put
      if (s_q.queue && sz != 6'h00 && pend_n[5'(ded + 6'(s_q.put_off))]) begin
         for (int k = NBUF - 1; k >= 1; k--) begin
            if (6'(k) < sz && !pend_n[5'(ded + 6'(wrap(6'(s_q.put_off) + 6'(k), sz)))]) begin
               step = 6'(k);
            end
         end
         s_d.put_off = wrap(6'(s_q.put_off) + step, sz);
      end
      if (!s_q.queue) begin
         s_d.put_off = 5'h00;
      end
      if (s_q.queue) begin
         s_d.get_off = 5'h00;
         s_d.fill    = 6'h00;
      end

      // Sticky events; a new event beats a write-one-to-clear in the same cycle
      s_d.full = full_now;
      ev = 3'b000;
      ev[IRQ_DONE]   = eng_i.done;
      ev[IRQ_CANCEL] = (cancel_m != 32'h0);
      ev[IRQ_FULL]   = full_now && !s_q.full;
      if (bus.wr && bus.addr == A_IRQ_ST) begin
         s_d.irq_st = s_q.irq_st & ~bus.wdata[2:0];
      end
      s_d.irq_st = s_d.irq_st | ev;

      // Read data, one cycle after the strobe
      if (bus.rd) begin
         case (bus.addr)
            A_CFG:      s_d.rdata = {s_q.queue, 1'b0, s_q.size, 2'b00, s_q.ded, s_q.start};
            A_ELEM:     s_d.rdata = {27'h0, s_q.elem};
            A_STAT: begin
               s_d.rdata = {26'h0, free_lvl};
               s_d.rdata[ST_GET_LSB +: 5] = s_q.queue ? 5'h00 : get_abs;
               s_d.rdata[ST_PUT_LSB +: 5] = put_abs;
               s_d.rdata[ST_FULL]         = full_now;
            end
            A_PEND:     s_d.rdata = s_q.pend;
            A_IRQ_ST:   s_d.rdata = {29'h0, s_q.irq_st};
            A_IRQ_MASK: s_d.rdata = {29'h0, s_q.irq_mask};
            A_NEXT:     s_d.rdata = {16'h0, put_addr};
            A_ID_SEL:   s_d.rdata = {27'h0, s_q.id_sel};
            A_ID_DATA:  s_d.rdata = {3'h0, s_q.ids[s_q.id_sel]};
            default:    s_d.rdata = 32'h0;
         endcase
      end

      // Offer the winner to the protocol engine
      // engine offer
      s_d.tx.valid = win_found;
      s_d.tx.index = win_idx;
      s_d.tx.id    = s_q.ids[win_idx];
      s_d.tx.addr  = s_q.start + 16'(10'(win_idx) * 10'(s_q.elem));
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q      <= '0;
         s_q.elem <= RST_ELEM;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign eng_o = s_q.tx;
   assign irq   = |(s_q.irq_st & s_q.irq_mask); // Level, drops when the bit is cleared

   property p_full_rd;
      @(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == A_STAT && !s_q.queue && sz != 6'h00 && s_q.fill == sz) |=> rdata[ST_FULL];
   endproperty
   a_full_rd: assert property (p_full_rd) else $error("full not reported");

   property p_add1;
      @(posedge clk) disable iff (!rst_n)
      (wr_add && !s_q.queue && !eng_i.done && !full_now && bus.wdata == (32'h1 << put_abs)
       && s_q.fill != 6'h00) |=> s_q.fill == $past(s_q.fill) + 6'h01 && $stable(s_q.get_off);
   endproperty
   a_add1: assert property (p_add1) else $error("single add did not advance put");

   property p_addn;
      @(posedge clk) disable iff (!rst_n)
      (wr_add && !s_q.queue && clr == 32'h0) |=> s_q.fill == $past(s_q.fill) + $past(add_cnt);
   endproperty
   a_addn: assert property (p_addn) else $error("batch add count wrong");

   property p_cancel_get;
      @(posedge clk) disable iff (!rst_n)
      (wr_cancel && !wr_add && !s_q.queue && s_q.fill != 6'h00 && bus.wdata[get_abs] && s_q.pend[get_abs])
      |=> s_q.fill < $past(s_q.fill);
   endproperty
   a_cancel_get: assert property (p_cancel_get) else $error("get not moved on cancel");

   property p_cancel_other;
      @(posedge clk) disable iff (!rst_n)
      (wr_cancel && !eng_i.done && !s_q.queue && !bus.wdata[get_abs]) |=> $stable(s_q.get_off)
      && s_q.fill == $past(s_q.fill) + $past(add_cnt);
   endproperty
   a_cancel_other: assert property (p_cancel_other) else $error("cancel moved get");

   property p_done;
      @(posedge clk) disable iff (!rst_n)
      (eng_i.done && eng_i.index == get_abs && !s_q.queue && s_q.fill != 6'h00 && !wr_add)
      |=> s_q.fill < $past(s_q.fill) ##1 !s_q.full;
   endproperty
   a_done: assert property (p_done) else $error("done did not free slot");

   property p_qput;
      @(posedge clk) disable iff (!rst_n) (s_q.queue && !full_now) |-> !s_q.pend[put_abs];
   endproperty
   a_qput: assert property (p_qput) else $error("queue put index busy");

   property p_mode;
      @(posedge clk) disable iff (!rst_n) s_q.queue |=> s_q.fill == 6'h00 || !s_q.queue;
   endproperty
   a_mode: assert property (p_mode) else $error("queue mode kept fifo fill");

   property p_area;
      @(posedge clk) disable iff (!rst_n) eng_o.valid |-> 6'(eng_o.index) < $past(ded + sz);
   endproperty
   a_area: assert property (p_area) else $error("offer outside area");

   property p_fifo_head;
      @(posedge clk) disable iff (!rst_n)
      (eng_o.valid && !$past(s_q.queue) && 6'(eng_o.index) >= $past(ded)) |-> eng_o.index == $past(get_abs);
   endproperty
   a_fifo_head: assert property (p_fifo_head) else $error("fifo entry not at get");

   c_full:  cover property (@(posedge clk) disable iff (!rst_n) !s_q.queue && full_now);
   c_qfull: cover property (@(posedge clk) disable iff (!rst_n) s_q.queue && full_now);
   c_cget:  cover property (@(posedge clk) disable iff (!rst_n) wr_cancel && bus.wdata[get_abs] && s_q.fill > 6'h01);
   c_mixed: cover property (@(posedge clk) disable iff (!rst_n) eng_o.valid && 6'(eng_o.index) < ded && s_q.fill != 6'h00);
endmodule

// [bench/ctxq_eng_model.sv]
`timescale 1ns/1ns
module ctxq_eng_model (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Pace control
   input  wire logic                    en,
   input  wire logic [3:0]              delay,
   // Block side
   input  wire ctxq_pkg::ctxq_eng_out_s eng_o,
   output ctxq_pkg::ctxq_eng_in_s       eng_i
);
   import ctxq_pkg::*;
   logic [3:0] wait_q;
   logic [2:0] hold_q;

   // Sends the offered buffer after a delay; the gap after each send lets the offer refresh
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_i  <= '0;
         wait_q <= 4'h0;
         hold_q <= 3'h0;
      end else begin
         eng_i.done  <= 1'b0;
         eng_i.index <= ~eng_i.index;  // Index carries no meaning outside a done pulse
         if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
         end else if (en && eng_o.valid) begin
            if (wait_q == delay) begin
               eng_i.done  <= 1'b1;
               eng_i.index <= eng_o.index;
               wait_q      <= 4'h0;
               hold_q      <= 3'h3;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule

// [bench/ctxq_core_tb.sv]
`timescale 1ns/1ns
module ctxq_core_tb;
   import ctxq_pkg::*;
   logic          clk;
   logic          rst_n;
   ctxq_bus_s     bus;
   logic [31:0]   rdata;
   ctxq_eng_in_s  eng_i;
   ctxq_eng_out_s eng_o;
   logic          irq;
   logic          en;
   logic [3:0]    delay;
   logic [4:0]    sent[$];
   logic [15:0]   start;
   logic [15:0]   elem;
   int            n_mismatch = 0;
   int            samples_checked = 0;
   int            cycles = 0;
   logic [31:0]   v;
   logic [28:0]   ids_tb [32] = '{default: 29'h0};

   ctxq_core dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .eng_i(eng_i), .eng_o(eng_o), .irq(irq));
   ctxq_eng_model eng_u (.clk(clk), .rst_n(rst_n), .en(en), .delay(delay), .eng_o(eng_o), .eng_i(eng_i));

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_of_test();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      samples_checked++;
      if ((got & m) !== (exp & m)) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got & m, exp & m);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp, m);
   endtask

   function automatic logic [31:0] stat(input int fr, input int g, input int p, input int f);
      return (32'(f) << ST_FULL) | (32'(p) << ST_PUT_LSB) | (32'(g) << ST_GET_LSB) | 32'(fr);
   endfunction

   task automatic set_id(input logic [4:0] b, input logic [31:0] id);
      ids_tb[b] = id[28:0];
      wr(A_ID_SEL, {27'h0, b});
      wr(A_ID_DATA, id);
   endtask

   // Lets the engine drain n buffers and compares the send order
   task automatic drain(input int n, input logic [19:0] exp, input logic [3:0] dl);
      int k;
      sent.delete();
      delay <= dl;
      en    <= 1'b1;
      for (k = 0; k < 300 && sent.size() < n; k++) @(posedge clk);
      en <= 1'b0;
      chk(32'(sent.size()), 32'(n), 32'hFFFFFFFF);
      for (k = 0; k < n && k < sent.size(); k++) chk({27'h0, sent[k]}, {27'h0, exp[k*5+:5]}, 32'h1F);
      repeat (4) @(posedge clk);
   endtask

   // Engine log and offered address check
   always @(posedge clk) begin
      if (rst_n === 1'b1 && eng_i.done === 1'b1) begin
         sent.push_back(eng_i.index);
         chk({16'h0, eng_o.addr}, {16'h0, start + 16'(eng_i.index) * elem}, 32'hFFFF);
         chk({3'h0, eng_o.id}, {3'h0, ids_tb[eng_i.index]}, 32'h1FFF_FFFF);
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   initial begin
      rst_n = 1'b0;
      bus   = '0;
      en    = 1'b0;
      delay = 4'h0;
      start = 16'h0100;
      elem  = 16'h0005;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rchk(A_ELEM, 32'(RST_ELEM), 32'h1F);
      rchk(8'h30, 32'h0, 32'hFFFFFFFF);
      rchk(A_STAT, 32'h0, 32'hFFFFFFFF);
      // FIFO with two dedicated buffers ahead of it
      wr(A_CFG, 32'h0402_0100);
      wr(A_ELEM, 32'h5);
      rchk(A_CFG, 32'h0402_0100, 32'hFFFFFFFF);
      rchk(A_STAT, stat(4, 2, 2, 0), 32'hFFFFFFFF);
      rchk(A_NEXT, 32'h0000_010A, 32'hFFFF);
      wr(A_ADD, 32'h1C);
      rchk(A_STAT, stat(1, 2, 5, 0), 32'hFFFFFFFF);
      wr(A_ADD, 32'h20);
      rchk(A_STAT, stat(0, 2, 2, 1), 32'hFFFFFFFF);
      wr(A_IRQ_MASK, 32'h4);
      // Look after the edge that registers the mask, not in its time step
      #1 chk({31'h0, irq}, 32'h1, 32'h1);
      wr(A_IRQ_ST, 32'h4);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0, 32'h1);
      wr(A_CANCEL, 32'h10);
      rchk(A_STAT, stat(0, 2, 2, 1), 32'hFFFFFFFF);
      wr(A_CANCEL, 32'h04);
      rchk(A_STAT, stat(1, 3, 2, 0), 32'hFFFFFFFF);
      drain(2, {10'h0, 5'd5, 5'd3}, 4'h2);
      rchk(A_STAT, stat(4, 2, 2, 0), 32'hFFFFFFFF);
      rchk(A_IRQ_ST, 32'h1, 32'h1);
      // Dedicated buffers against the FIFO head only
      set_id(5'd0, 32'h200);
      set_id(5'd1, 32'h050);
      set_id(5'd2, 32'h100);
      set_id(5'd3, 32'h010);
      wr(A_ADD, 32'h0F);
      drain(4, {5'd0, 5'd3, 5'd2, 5'd1}, 4'h0);
      // Queue mode
      start = 16'h0200;
      wr(A_CFG, 32'h8400_0200);
      set_id(5'd0, 32'h30);
      set_id(5'd1, 32'h10);
      set_id(5'd2, 32'h10);
      set_id(5'd3, 32'h20);
      rchk(A_ID_DATA, 32'h20, 32'h1FFF_FFFF);
      rchk(A_STAT, stat(0, 0, 0, 0), 32'h011F_1F00);
      wr(A_ADD, 32'h1);
      rchk(A_STAT, stat(0, 0, 1, 0), 32'h011F_0000);
      wr(A_ADD, 32'h2);
      wr(A_ADD, 32'hC);
      rchk(A_STAT, stat(0, 0, 0, 1), 32'h0100_0000);
      drain(4, {5'd0, 5'd3, 5'd2, 5'd1}, 4'h4);
      rchk(A_STAT, stat(0, 0, 0, 0), 32'h0100_0000);
      rchk(A_PEND, 32'h0, 32'hFFFFFFFF);
      // Dedicated only, in both modes
      for (int m = 0; m < 2; m++) begin
         wr(A_CFG, (32'(m) << CFG_QUEUE) | 32'h0002_0000);
         wr(A_ADD, 32'h6);
         rchk(A_PEND, 32'h2, 32'hFFFFFFFF);
         wr(A_CANCEL, 32'h6);
         rchk(A_PEND, 32'h0, 32'hFFFFFFFF);
      end
      end_of_test();
   end
endmodule
